// file: rwa_window.v
// Calendar window access, write lock and alarm repeat match.
// Assumes BCD calendar values come from the timekeeping counters outside.
//
// Summary of operation
// - Time window shows pair chosen by pointer
// - Alarm pointer is config bits nine to eight
// - Alarm window pairs; code three shows nothing
// - Alarm high write decrements pointer, stops zero
// - Any alarm window read decrements pointer
// - Any time window read decrements pointer
// - Low byte writes leave pointer unchanged
// - Time writes ignored unless write enable set
// - Enable accepted with unlock or one cycle after
// - Yearly alarm skips February twenty-ninth
// - Time pointer bits nine to eight, decrements
`timescale 1ns/1ns
`default_nettype none
module rwa_window (
   input  wire        clk_sys,
   input  wire        resetn,
   // Configuration writes
   input  wire        cal_cfg_wr,
   input  wire [15:0] cal_cfg_wdata,
   input  wire        alm_cfg_wr,
   input  wire [15:0] alm_cfg_wdata,
   input  wire        unlock_done,
   // Time window access
   input  wire        time_rd,
   input  wire        time_wr_high,
   input  wire        time_wr_low,
   input  wire [15:0] time_wdata,
   // Alarm window access
   input  wire        alarm_rd,
   input  wire        alarm_wr_high,
   input  wire        alarm_wr_low,
   input  wire [15:0] alarm_wdata,
   // Current calendar values
   input  wire [7:0]  cur_year,
   input  wire [7:0]  cur_month,
   input  wire [7:0]  cur_day,
   input  wire [7:0]  cur_weekday,
   input  wire [7:0]  cur_hours,
   input  wire [7:0]  cur_minutes,
   input  wire [7:0]  cur_seconds,
   input  wire        half_sec_tick,
   input  wire        sec_tick,
   // Outputs
   output reg  [15:0] time_rdata,
   output reg  [15:0] alarm_rdata,
   output reg  [1:0]  time_pointer_out,
   output reg  [1:0]  alarm_pointer_out,
   output reg         time_write_enable,
   output reg         time_wr_strobe,
   output reg  [1:0]  time_wr_sel,
   output reg  [15:0] time_wr_data,
   output reg  [3:0]  alarm_repeat_mask,
   output reg         alarm_match
);
`include "rwa_consts.vh"
   // ----------------------------------------
   // Pointers
   // ----------------------------------------
   wire [1:0] time_pointer;
   wire [1:0] alarm_pointer;
   rwa_ptr u_time_ptr (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .load     (cal_cfg_wr),
      .load_val (cal_cfg_wdata[`RWA_PTR_MSB:`RWA_PTR_LSB]),
      .step     (time_rd | time_wr_high),
      .ptr      (time_pointer)
   );
   rwa_ptr u_alarm_ptr (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .load     (alm_cfg_wr),
      .load_val (alm_cfg_wdata[`RWA_PTR_MSB:`RWA_PTR_LSB]),
      .step     (alarm_rd | alarm_wr_high),
      .ptr      (alarm_pointer)
   );
   // ----------------------------------------
   // Alarm registers
   // ----------------------------------------
   reg [7:0] alarm_minutes;
   reg [7:0] alarm_seconds;
   reg [7:0] alarm_weekday;
   reg [7:0] alarm_hours;
   reg [7:0] alarm_month;
   reg [7:0] alarm_day;
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         alarm_minutes <= 8'h00;
         alarm_seconds <= 8'h00;
         alarm_weekday <= 8'h00;
         alarm_hours   <= 8'h00;
         alarm_month   <= `RWA_DATE_RESET;
         alarm_day     <= `RWA_DATE_RESET;
      end else begin
         case (alarm_pointer)
            2'h0: begin
               if (alarm_wr_high) alarm_minutes <= alarm_wdata[15:8];
               if (alarm_wr_low)  alarm_seconds <= alarm_wdata[7:0];
            end
            2'h1: begin
               if (alarm_wr_high) alarm_weekday <= alarm_wdata[15:8];
               if (alarm_wr_low)  alarm_hours   <= alarm_wdata[7:0];
            end
            2'h2: begin
               if (alarm_wr_high) alarm_month <= alarm_wdata[15:8];
               if (alarm_wr_low)  alarm_day   <= alarm_wdata[7:0];
            end
            default: begin
            end
         endcase
      end
   end
   // ----------------------------------------
   // Write lock
   // ----------------------------------------
   // Unlock window is a one-cycle grace after the sequence
   reg unlock_open;
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         unlock_open       <= 1'b0;
         time_write_enable <= 1'b0;
      end else begin
         unlock_open <= unlock_done;
         if (cal_cfg_wr) begin
            if (!cal_cfg_wdata[`RWA_WREN_BIT])
               time_write_enable <= 1'b0;
            else if (unlock_open || unlock_done)
               time_write_enable <= 1'b1;
         end
      end
   end
   // Locked writes are dropped, not queued
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         time_wr_strobe <= 1'b0;
         time_wr_sel    <= 2'h0;
         time_wr_data   <= 16'h0000;
      end else begin
         time_wr_strobe <= time_write_enable & (time_wr_high | time_wr_low);
         // Select and data hold the last accepted write
         if (time_write_enable && (time_wr_high || time_wr_low)) begin
            time_wr_sel  <= time_pointer;
            time_wr_data <= time_wdata;
         end
      end
   end
   // ----------------------------------------
   // Read windows
   // ----------------------------------------
   reg [15:0] next_time_rdata;
   reg [15:0] next_alarm_rdata;
   always @* begin
      case (time_pointer)
         2'h0:    next_time_rdata = {cur_minutes, cur_seconds};
         2'h1:    next_time_rdata = {cur_weekday, cur_hours};
         2'h2:    next_time_rdata = {cur_month, cur_day};
         default: next_time_rdata = {8'h00, cur_year};
      endcase
      case (alarm_pointer)
         2'h0:    next_alarm_rdata = {alarm_minutes, alarm_seconds};
         2'h1:    next_alarm_rdata = {alarm_weekday, alarm_hours};
         2'h2:    next_alarm_rdata = {alarm_month, alarm_day};
         default: next_alarm_rdata = 16'h0000;
      endcase
   end
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         time_rdata        <= 16'h0000;
         alarm_rdata       <= 16'h0000;
         time_pointer_out  <= `RWA_PTR_RESET;
         alarm_pointer_out <= `RWA_PTR_RESET;
      end else begin
         time_rdata        <= next_time_rdata;
         alarm_rdata       <= next_alarm_rdata;
         time_pointer_out  <= time_pointer;
         alarm_pointer_out <= alarm_pointer;
      end
   end
   // ----------------------------------------
   // Alarm repeat match
   // ----------------------------------------
   wire eq_s1  = cur_seconds[3:0] == alarm_seconds[3:0];
   wire eq_s   = cur_seconds == alarm_seconds;
   wire eq_m1  = cur_minutes[3:0] == alarm_minutes[3:0];
   wire eq_m   = cur_minutes == alarm_minutes;
   wire eq_h   = cur_hours == alarm_hours;
   wire eq_wd  = cur_weekday == alarm_weekday;
   wire eq_d   = cur_day == alarm_day;
   wire eq_mo  = cur_month == alarm_month;
   wire leap29 = alarm_month == `RWA_FEB && alarm_day == `RWA_DAY29;
   reg next_match;
   always @* begin
      case (alarm_repeat_mask)
         `RWA_MASK_HALF_SEC: next_match = half_sec_tick;
         `RWA_MASK_SEC:      next_match = sec_tick;
         `RWA_MASK_TEN_SEC:  next_match = sec_tick & eq_s1;
         `RWA_MASK_MIN:      next_match = sec_tick & eq_s;
         `RWA_MASK_TEN_MIN:  next_match = sec_tick & eq_s & eq_m1;
         `RWA_MASK_HOUR:     next_match = sec_tick & eq_s & eq_m;
         `RWA_MASK_DAY:      next_match = sec_tick & eq_s & eq_m & eq_h;
         `RWA_MASK_WEEK:     next_match = sec_tick & eq_s & eq_m & eq_h & eq_wd;
         `RWA_MASK_MONTH:    next_match = sec_tick & eq_s & eq_m & eq_h & eq_d;
         `RWA_MASK_YEAR:     next_match = sec_tick & eq_s & eq_m & eq_h & eq_d & eq_mo & ~leap29;
         default:            next_match = 1'b0;
      endcase
   end
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         alarm_repeat_mask <= `RWA_MASK_HALF_SEC;
         alarm_match       <= 1'b0;
      end else begin
         if (alm_cfg_wr)
            alarm_repeat_mask <= alm_cfg_wdata[`RWA_MASK_MSB:`RWA_MASK_LSB];
         alarm_match <= next_match;
      end
   end
endmodule // rwa_window
`default_nettype wire

// file: rwa_consts.vh
// Constants for the calendar window access block.
// Assumes inclusion by bare name from the design files.
`ifndef RWA_CONSTS_VH
`define RWA_CONSTS_VH
`define RWA_PTR_MSB        9
`define RWA_PTR_LSB        8
`define RWA_WREN_BIT       13
`define RWA_MASK_MSB       13
`define RWA_MASK_LSB       10
`define RWA_DATE_RESET     8'h01
`define RWA_PTR_RESET      2'h0
`define RWA_PTR_MIN        2'h0
`define RWA_UNLOCK_CYCLES  4'h1
`define RWA_MASK_HALF_SEC  4'h0
`define RWA_MASK_SEC       4'h1
`define RWA_MASK_TEN_SEC   4'h2
`define RWA_MASK_MIN       4'h3
`define RWA_MASK_TEN_MIN   4'h4
`define RWA_MASK_HOUR      4'h5
`define RWA_MASK_DAY       4'h6
`define RWA_MASK_WEEK      4'h7
`define RWA_MASK_MONTH     4'h8
`define RWA_MASK_YEAR      4'h9
`define RWA_FEB            8'h02
`define RWA_DAY29          8'h29
`endif

// file: rwa_ptr.v
// Two-bit window pointer with load and saturating decrement.
// Assumes load and step requests are single-cycle strobes.
`timescale 1ns/1ns
`default_nettype none
module rwa_ptr (
   input  wire       clk_sys,
   input  wire       resetn,
   input  wire       load,
   input  wire [1:0] load_val,
   input  wire       step,
   output reg  [1:0] ptr
);
`include "rwa_consts.vh"
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ptr <= `RWA_PTR_RESET;
      end else if (load) begin
         ptr <= load_val;
      end else if (step && ptr != `RWA_PTR_MIN) begin
         // Saturates at zero, stays on minutes and seconds
         ptr <= ptr - 2'h1;
      end
   end
endmodule // rwa_ptr
`default_nettype wire

// file: rwa_window_properties.sv
// Checker for the window access block.
// Assumes binding onto rwa_window; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module rwa_props (
   input wire logic        clk_sys,
   input wire logic        resetn,
   input wire logic        cal_cfg_wr,
   input wire logic [15:0] cal_cfg_wdata,
   input wire logic        alm_cfg_wr,
   input wire logic        unlock_done,
   input wire logic        time_rd,
   input wire logic        time_wr_high,
   input wire logic        time_wr_low,
   input wire logic        alarm_rd,
   input wire logic        alarm_wr_high,
   input wire logic [7:0]  cur_weekday,
   input wire logic [7:0]  cur_hours,
   input wire logic        sec_tick,
   input wire logic [15:0] time_rdata,
   input wire logic [15:0] alarm_rdata,
   input wire logic [1:0]  time_pointer_out,
   input wire logic [1:0]  alarm_pointer_out,
   input wire logic        time_write_enable,
   input wire logic        time_wr_strobe,
   input wire logic [3:0]  alarm_repeat_mask,
   input wire logic        alarm_match
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Unlock then enable request, same or next cycle
   sequence s_unlock;
      unlock_done ##[0:1] (cal_cfg_wr && cal_cfg_wdata[13]);
   endsequence
   property p_adec;
      (alarm_wr_high || alarm_rd) && !alm_cfg_wr |=> ##1
         alarm_pointer_out == (($past(alarm_pointer_out) == 2'h0) ? 2'h0 : $past(alarm_pointer_out) - 2'h1);
   endproperty
   property p_tdec;
      (time_wr_high || time_rd) && !cal_cfg_wr |=> ##1
         time_pointer_out == (($past(time_pointer_out) == 2'h0) ? 2'h0 : $past(time_pointer_out) - 2'h1);
   endproperty
   property p_unlock;
      s_unlock |=> time_write_enable;
   endproperty
   property p_lock;
      time_wr_strobe |-> $past(time_write_enable && (time_wr_high || time_wr_low));
   endproperty
   property p_rsv;
      $past(alarm_repeat_mask) > 4'h9 |-> !alarm_match;
   endproperty
   property p_sec;
      alarm_repeat_mask == 4'h1 && sec_tick |=> alarm_match;
   endproperty
   property p_tw;
      $past(resetn) && time_pointer_out == 2'h1 |-> time_rdata == {$past(cur_weekday), $past(cur_hours)};
   endproperty
   property p_aw;
      alarm_pointer_out == 2'h3 |-> alarm_rdata == 16'h0;
   endproperty
   a_adec: assert property (p_adec) else $error("alarm pointer step wrong");
   a_tdec: assert property (p_tdec) else $error("time pointer step wrong");
   a_unlock: assert property (p_unlock) else $error("enable not set");
   a_lock: assert property (p_lock) else $error("write while locked");
   a_rsv: assert property (p_rsv) else $error("reserved mask matched");
   a_sec: assert property (p_sec) else $error("no match each second");
   a_tw: assert property (p_tw) else $error("time window pair wrong");
   a_aw: assert property (p_aw) else $error("alarm code three not zero");
endmodule // rwa_props
bind rwa_window rwa_props u_props (.clk_sys, .resetn, .cal_cfg_wr, .cal_cfg_wdata, .alm_cfg_wr, .unlock_done,
   .time_rd, .time_wr_high, .time_wr_low, .alarm_rd, .alarm_wr_high, .cur_weekday, .cur_hours, .sec_tick,
   .time_rdata, .alarm_rdata, .time_pointer_out, .alarm_pointer_out, .time_write_enable, .time_wr_strobe,
   .alarm_repeat_mask, .alarm_match);
`default_nettype wire

// file: tb_top.sv
// Testbench for the window access block.
// Assumes rwa_window and its checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic        cal_cfg_wr, alm_cfg_wr, unlock_done, time_rd, time_wr_high, time_wr_low;
   logic        alarm_rd, alarm_wr_high, alarm_wr_low, half_sec_tick, sec_tick, sw, mt;
   logic [15:0] wd = 16'h0;
   logic [7:0]  cur_year = 8'h24, cur_month = 8'h03, cur_day = 8'h15, cur_weekday = 8'h02;
   logic [7:0]  cur_hours = 8'h13, cur_minutes = 8'h45, cur_seconds = 8'h30;
   logic [15:0] time_rdata, alarm_rdata, time_wr_data;
   logic [1:0]  time_pointer_out, alarm_pointer_out, time_wr_sel;
   logic [3:0]  alarm_repeat_mask;
   logic        time_write_enable, time_wr_strobe, alarm_match;
   logic [15:0] twin [4] = '{16'h4530, 16'h0213, 16'h0315, 16'h0024};
   integer      failures = 0;
   integer      comparisons = 0;
   integer      i;
   localparam [10:0] cc = 11'h1, ac = 11'h2, ul = 11'h4, tr = 11'h8, twh = 11'h10, twl = 11'h20;
   localparam [10:0] ar = 11'h40, awh = 11'h80, awl = 11'h100, tk = 11'h600;
   always #50 clk_sys = ~clk_sys;
   rwa_window dut_u (.clk_sys, .resetn, .cal_cfg_wr, .cal_cfg_wdata(wd), .alm_cfg_wr, .alm_cfg_wdata(wd),
      .unlock_done, .time_rd, .time_wr_high, .time_wr_low, .time_wdata(wd), .alarm_rd, .alarm_wr_high,
      .alarm_wr_low, .alarm_wdata(wd), .cur_year, .cur_month, .cur_day, .cur_weekday, .cur_hours, .cur_minutes,
      .cur_seconds, .half_sec_tick, .sec_tick, .time_rdata, .alarm_rdata, .time_pointer_out, .alarm_pointer_out,
      .time_write_enable, .time_wr_strobe, .time_wr_sel, .time_wr_data, .alarm_repeat_mask, .alarm_match);
   // ----
   // Access tasks, entered and left at a falling edge
   // ----
   task go(input [10:0] s);
      {sec_tick, half_sec_tick, alarm_wr_low, alarm_wr_high, alarm_rd, time_wr_low, time_wr_high, time_rd,
       unlock_done, alm_cfg_wr, cal_cfg_wr} = s;
      @(negedge clk_sys);
   endtask
   // Pulses are caught over two cycles, as the answer lag is one edge
   task step(input [10:0] s, input [15:0] d);
      wd = d;
      go(s);
      sw = time_wr_strobe;
      mt = alarm_match;
      go(0);
      sw = sw | time_wr_strobe;
      mt = mt | alarm_match;
      go(0);
   endtask
   task chk(input string n, input [17:0] e, input [17:0] g);
      comparisons = comparisons + 1;
      if (g !== e) begin
         failures = failures + 1;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task ast(input [10:0] s, input [15:0] d, input [17:0] e);
      step(s, d);
      chk("alarm window", e, {alarm_pointer_out, alarm_rdata});
   endtask
   task tst(input [10:0] s, input [15:0] d, input [3:0] e);
      step(s, d);
      chk("lock", e, {time_write_enable, sw, time_pointer_out});
   endtask
   // One tick per repeat code; bit n of hit says whether code n matches
   task sweep(input [15:0] hit);
      integer k;
      for (k = 0; k < 16; k++) begin
         step(ac, {2'h0, k[3:0], 10'h0});
         step(tk, 16'h0);
         chk("mask", {k[3:0], hit[k]}, {alarm_repeat_mask, mt});
      end
   endtask
   task give_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ----
   // Sequence
   // ----
   initial begin
      repeat (20) go(0);
      resetn = 1'b1;
      step(cc, 16'h0300);
      for (i = 3; i >= -1; i--) begin
         chk("time window", {i < 0 ? 2'h0 : i[1:0], twin[i < 0 ? 0 : i]}, {time_pointer_out, time_rdata});
         step(tr, 16'h0);
      end
      tst(cc, 16'h2300, 4'h3);
      tst(twl, 16'h0a0b, 4'h3);
      chk("write", 18'h00000, {time_wr_sel, time_wr_data});
      go(ul);
      tst(cc, 16'h2200, 4'ha);
      tst(twh, 16'h0a0b, 4'hd);
      chk("write", 18'h20a0b, {time_wr_sel, time_wr_data});
      tst(twl, 16'h0c0d, 4'hd);
      chk("write", 18'h10c0d, {time_wr_sel, time_wr_data});
      tst(cc, 16'h0000, 4'h0);
      tst(ul | cc, 16'h2100, 4'h9);
      tst(cc, 16'h0000, 4'h0);
      go(ul);
      go(0);
      go(0);
      tst(cc, 16'h2000, 4'h0);
      ast(ac, 16'h0300, {2'h3, 16'h0000});
      ast(awh, 16'h5500, {2'h2, 16'h0101});
      ast(awh, 16'h1200, {2'h1, 16'h0000});
      ast(awl, 16'h0007, {2'h1, 16'h0007});
      ast(ar, 16'h0000, {2'h0, 16'h0000});
      ast(ar, 16'h0000, {2'h0, 16'h0000});
      ast(ac, 16'h0200, {2'h2, 16'h1201});
      sweep(16'h0007);
      cur_seconds = 8'h00;
      cur_minutes = 8'h00;
      sweep(16'h003f);
      {cur_hours, cur_weekday, cur_day, cur_month} = 32'h07000112;
      sweep(16'h03ff);
      {cur_weekday, cur_month} = 16'h0511;
      sweep(16'h017f);
      // Half-second tick alone
      step(ac, 16'h0000);
      step(11'h200, 16'h0);
      chk("half tick", 5'h01, {alarm_repeat_mask, mt});
      step(ac, 16'h0400);
      step(11'h200, 16'h0);
      chk("half tick", 5'h02, {alarm_repeat_mask, mt});
      // Alarm on the twenty-ninth of February
      ast(ac, 16'h0200, {2'h2, 16'h1201});
      ast(awl, 16'h0029, {2'h2, 16'h1229});
      ast(awh, 16'h0200, {2'h1, 16'h0007});
      {cur_weekday, cur_month, cur_day} = 24'h000229;
      step(ac, {2'h0, 4'h9, 10'h0});
      step(tk, 16'h0);
      chk("leap", 5'h12, {alarm_repeat_mask, mt});
      step(ac, {2'h0, 4'h8, 10'h0});
      step(tk, 16'h0);
      chk("leap", 5'h11, {alarm_repeat_mask, mt});
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
